// File: hdl/asc_pkg.sv
// Constants for the converter sample/convert control block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package asc_pkg;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_RESULT = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_MASK   = 12'h00c;
  localparam logic [11:0] ADDR_SAMPT  = 12'h010;

  localparam int BIT_ON   = 15;
  localparam int BIT_STOP_IN_IDLE = 13;
  localparam int BIT_FMT  = 8;
  localparam int BIT_TRG  = 5;
  localparam int BIT_ACLR = 4;
  localparam int BIT_AUTO_SAMPLE_START = 2;
  localparam int BIT_SAMPLE_BIT = 1;
  localparam int BIT_DONE = 0;

  // Writable control bits: 15, 13, 10:8, 7:4, 2:0
  localparam logic [31:0] CTRL_MASK  = 32'h0000_a7f7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  localparam logic [7:0] SAMPT_RESET = 8'h04;

  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TRIG = 1;
  localparam int IRQ_W    = 2;

  typedef enum logic [2:0] {
    ASC_TRG_SOFT  = 3'b000,
    ASC_TRG_PIN   = 3'b001,
    ASC_TRG_TMR   = 3'b010,
    ASC_TRG_CHARGE_TIME_UNIT  = 3'b011,
    ASC_TRG_AUTO  = 3'b111
  } asc_trg_t;

  typedef enum logic [2:0] {
    ASC_FMT_INT16  = 3'b000,
    ASC_FMT_SINT16 = 3'b001,
    ASC_FMT_FRC16  = 3'b010,
    ASC_FMT_SFRC16 = 3'b011,
    ASC_FMT_INT32  = 3'b100,
    ASC_FMT_SINT32 = 3'b101,
    ASC_FMT_FRC32  = 3'b110,
    ASC_FMT_SFRC32 = 3'b111
  } asc_fmt_t;

  typedef enum logic [1:0] {
    ASC_IDLE    = 2'b00,
    ASC_SAMPLE  = 2'b01,
    ASC_CONVERT = 2'b10
  } asc_state_t;
endpackage : asc_pkg

// File: hdl/asc_format.sv
// Result formatter: packs a raw converter result into the output word.
// Assumes an offset-binary result; signed forms flip the top bit.
`timescale 1ns/100ps
module asc_format #(
  parameter int RES_W = 10
) (
  input  wire logic [2:0]       fmt,  // Output format code
  input  wire logic [RES_W-1:0] raw,  // Raw converter result
  output      logic [31:0]      word  // Formatted word
);
  wire logic [RES_W-1:0] sgn = {~raw[RES_W-1], raw[RES_W-2:0]};
  wire logic             s   = sgn[RES_W-1];
  wire logic [31:0] r_int = {{(32-RES_W){1'b0}}, raw};
  wire logic [31:0] r_s16 = {16'h0000, {(16-RES_W){s}}, sgn};
  wire logic [31:0] r_f16 = {16'h0000, raw, {(16-RES_W){1'b0}}};
  wire logic [31:0] r_sf16 = {16'h0000, sgn, {(16-RES_W){1'b0}}};
  wire logic [31:0] r_s32 = {{(32-RES_W){s}}, sgn};
  wire logic [31:0] r_f32 = {raw, {(32-RES_W){1'b0}}};
  wire logic [31:0] r_sf32 = {sgn, {(32-RES_W){1'b0}}};

  // Format selection
  always_comb begin
    unique case (asc_pkg::asc_fmt_t'(fmt))
      asc_pkg::ASC_FMT_INT16:  word = r_int;
      asc_pkg::ASC_FMT_SINT16: word = r_s16;
      asc_pkg::ASC_FMT_FRC16:  word = r_f16;
      asc_pkg::ASC_FMT_SFRC16: word = r_sf16;
      asc_pkg::ASC_FMT_INT32:  word = r_int;
      asc_pkg::ASC_FMT_SINT32: word = r_s32;
      asc_pkg::ASC_FMT_FRC32:  word = r_f32;
      asc_pkg::ASC_FMT_SFRC32: word = r_sf32;
    endcase
  end
endmodule : asc_format

// File: hdl/asc_ctrl.sv
// Converter control: APB registers, sampling/conversion sequencer,
// trigger selection, conversion-complete flag and interrupt.
// Assumes trigger inputs and core done are asynchronous to pclk;
// the analog core takes a start pulse and returns a done level/pulse.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module asc_ctrl #(
  parameter int RES_W = 10
) (
  input  wire logic              pclk,        // APB clock
  input  wire logic              presetn,     // Async reset, active low
  input  wire logic              psel,        // APB select
  input  wire logic              penable,     // APB enable
  input  wire logic              pwrite,      // APB direction
  input  wire logic [11:0]       paddr,       // APB byte address
  input  wire logic [31:0]       pwdata,      // APB write data
  output      logic [31:0]       prdata,      // APB read data
  output      logic              pready,      // APB ready
  output      logic              pslverr,     // APB error
  input  wire logic              idle_mode,   // Device idle, async
  input  wire logic              ext_pin_zero,// External pin 0, async
  input  wire logic              tmr3_match,  // Timer 3 period match
  input  wire logic              ctu_event,   // Charge-time unit event
  input  wire logic              conv_done,   // Core done, async
  input  wire logic [RES_W-1:0]  conv_result, // Core result
  output      logic              conv_start,  // Start-of-conversion pulse
  output      logic              sampling,    // Sample switch closed
  output      logic              adc_on,      // Analog core enable
  output      logic              irq          // Level interrupt
);
  // Synchronisers: first stage read only by second stage
  logic [4:0] sync1;
  logic [4:0] sync2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {idle_mode, ext_pin_zero, tmr3_match, ctu_event, conv_done};
      sync2 <= sync1;
    end
  end

  // Edge detect on synchronised inputs (third stage, not the first)
  logic [4:0] sync_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sync_d <= 5'h00;
    else
      sync_d <= sync2;
  end
  wire logic [4:0] rise   = sync2 & ~sync_d;
  wire logic       idle_s = sync2[4];

  // Registers; status width fixed before the declarations that use it
  localparam int IRQ_W_L = asc_pkg::IRQ_W;
  logic [31:0]       ctrl;
  logic [31:0]       result;
  logic [IRQ_W_L-1:0] status;
  logic [IRQ_W_L-1:0] mask;
  logic [7:0]        sampt;

  // APB decode: zero-wait slave, access completes in the access phase
  wire logic acc     = psel & penable;
  wire logic wr      = acc & pwrite;
  wire logic hit_ctl = paddr == asc_pkg::ADDR_CTRL;
  wire logic hit_res = paddr == asc_pkg::ADDR_RESULT;
  wire logic hit_sts = paddr == asc_pkg::ADDR_STATUS;
  wire logic hit_msk = paddr == asc_pkg::ADDR_MASK;
  wire logic hit_spt = paddr == asc_pkg::ADDR_SAMPT;
  wire logic hit_any = hit_ctl | hit_res | hit_sts | hit_msk | hit_spt;
  wire logic wr_ctl  = wr & hit_ctl;

  // Control fields
  wire logic       on_bit = ctrl[asc_pkg::BIT_ON];
  wire logic       stop_in_idle   = ctrl[asc_pkg::BIT_STOP_IN_IDLE];
  wire logic [2:0] fmt    = ctrl[asc_pkg::BIT_FMT +: 3];
  wire logic [2:0] trg    = ctrl[asc_pkg::BIT_TRG +: 3];
  wire logic       auto_sample_start   = ctrl[asc_pkg::BIT_AUTO_SAMPLE_START];
  wire logic       sample_bit   = ctrl[asc_pkg::BIT_SAMPLE_BIT];
  wire logic       done   = ctrl[asc_pkg::BIT_DONE];

  // Converter active: on, and not frozen by idle with stop-in-idle
  wire logic active = on_bit & ~(stop_in_idle & idle_s);

  // Selected hardware trigger; reserved codes never fire
  logic hw_trig;
  logic cnt_hit;
  always_comb begin
    unique case (trg)
      asc_pkg::ASC_TRG_PIN:  hw_trig = rise[3];
      asc_pkg::ASC_TRG_TMR:  hw_trig = rise[2];
      asc_pkg::ASC_TRG_CHARGE_TIME_UNIT: hw_trig = rise[1];
      asc_pkg::ASC_TRG_AUTO: hw_trig = cnt_hit;
      default:               hw_trig = 1'b0;
    endcase
  end

  // Sequencer state
  asc_pkg::asc_state_t state;
  asc_pkg::asc_state_t next_state;
  logic [7:0]          cnt;

  wire logic sw_sample_bit_set = wr_ctl & pwdata[asc_pkg::BIT_SAMPLE_BIT];
  wire logic sw_sample_bit_clr = wr_ctl & ~pwdata[asc_pkg::BIT_SAMPLE_BIT];
  wire logic is_soft     = trg == asc_pkg::ASC_TRG_SOFT;
  wire logic in_sample   = state == asc_pkg::ASC_SAMPLE;
  wire logic in_convert  = state == asc_pkg::ASC_CONVERT;
  assign cnt_hit = in_sample && (cnt >= sampt);

  // Start sampling: software write or auto start in idle
  wire logic begin_sample_bit = active && state == asc_pkg::ASC_IDLE &&
                          (auto_sample_start || sw_sample_bit_set);
  // End sampling / start conversion
  wire logic end_sample_bit = active && in_sample &&
                        (is_soft ? sw_sample_bit_clr : hw_trig);
  wire logic finish   = in_convert && rise[0];

  // Next state of the sequencer
  always_comb begin
    next_state = state;
    if (!on_bit)
      next_state = asc_pkg::ASC_IDLE;
    else if (begin_sample_bit)
      next_state = asc_pkg::ASC_SAMPLE;
    else if (end_sample_bit)
      next_state = asc_pkg::ASC_CONVERT;
    else if (finish)
      next_state = asc_pkg::ASC_IDLE;
  end

  // State and sample-time counter; counter frozen while stopped in idle, cleared outside sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= asc_pkg::ASC_IDLE;
      cnt   <= 8'h00;
    end else begin
      state <= next_state;
      if (next_state != asc_pkg::ASC_SAMPLE || begin_sample_bit)
        cnt <= 8'h00;
      else if (active)
        cnt <= cnt + 8'h01;
    end
  end

  // Next control word: writable bits from software, then hardware
  // updates. Hardware set of the complete flag wins over software clear.
  logic [31:0] next_ctrl;
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctl) begin
      next_ctrl = pwdata & asc_pkg::CTRL_MASK;
      next_ctrl[asc_pkg::BIT_DONE] =
        done & pwdata[asc_pkg::BIT_DONE];
    end
    if (!on_bit || next_state != asc_pkg::ASC_SAMPLE)
      next_ctrl[asc_pkg::BIT_SAMPLE_BIT] = 1'b0;
    if (next_state == asc_pkg::ASC_SAMPLE)
      next_ctrl[asc_pkg::BIT_SAMPLE_BIT] = 1'b1;
    if (end_sample_bit)
      next_ctrl[asc_pkg::BIT_DONE] = 1'b0;
    if (finish)
      next_ctrl[asc_pkg::BIT_DONE] = 1'b1;
  end

  // Formatted result of the core
  logic [31:0] fmt_word;
  asc_format #(
    .RES_W (RES_W)
  ) u_format (
    .fmt  (fmt),
    .raw  (conv_result),
    .word (fmt_word)
  );

  // Register writes; status bits are write-one-to-clear, set wins
  wire logic [IRQ_W_L-1:0] events = {end_sample_bit, finish};
  wire logic [IRQ_W_L-1:0] w1c =
    (wr & hit_sts) ? pwdata[IRQ_W_L-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= asc_pkg::CTRL_RESET;
      result <= 32'h0000_0000;
      status <= '0;
      mask   <= '0;
      sampt  <= asc_pkg::SAMPT_RESET;
    end else begin
      ctrl   <= next_ctrl;
      status <= (status & ~w1c) | events;
      if (finish)
        result <= fmt_word;
      if (wr & hit_msk)
        mask <= pwdata[IRQ_W_L-1:0];
      if (wr & hit_spt)
        sampt <= pwdata[7:0];
    end
  end

  // Read mux
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (hit_ctl)
      rmux = ctrl;
    else if (hit_res)
      rmux = result;
    else if (hit_sts)
      rmux[IRQ_W_L-1:0] = status;
    else if (hit_msk)
      rmux[IRQ_W_L-1:0] = mask;
    else if (hit_spt)
      rmux[7:0] = sampt;
  end

  // Registered outputs; read data launched in setup so it is valid
  // at the access edge, giving a zero-wait transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      conv_start <= 1'b0;
      sampling   <= 1'b0;
      adc_on     <= 1'b0;
      irq        <= 1'b0;
    end else begin
      prdata     <= (psel & ~penable & ~pwrite) ? rmux : 32'h0000_0000;
      pready     <= psel & ~penable;
      pslverr    <= psel & ~penable & ~hit_any;
      conv_start <= end_sample_bit;
      sampling   <= next_state == asc_pkg::ASC_SAMPLE;
      adc_on     <= next_ctrl[asc_pkg::BIT_ON];
      irq        <= |(((status & ~w1c) | events) & mask);
    end
  end
endmodule : asc_ctrl

// File: tb/asc_ctrl_asserts.sv
// Port checker for asc_ctrl: bus answers and sequencer outputs.
// Assumes zero-wait APB, registered outputs and one clock domain.
`timescale 1ns/100ps
module asc_ctrl_asserts (
  input wire logic        pclk,       // Clock
  input wire logic        presetn,    // Reset, active low
  input wire logic        psel,       // Select
  input wire logic        penable,    // Enable
  input wire logic        pwrite,     // Direction
  input wire logic [11:0] paddr,      // Address
  input wire logic [31:0] pwdata,     // Write data
  input wire logic [31:0] prdata,     // Read data
  input wire logic        pready,     // Ready
  input wire logic        pslverr,    // Error
  input wire logic        conv_start, // Start pulse
  input wire logic        sampling,   // Sampling level
  input wire logic        adc_on      // Enable copy
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Control word write completing on the bus
  wire ctl_wr = psel & penable & pready & pwrite &
                (paddr == asc_pkg::ADDR_CTRL);
  a_ready_access: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_ready_alone: assert property (pready |-> psel && penable)
    else $error("ready outside access cycle");
  a_err_refused: assert property (pslverr |-> pready && prdata == '0)
    else $error("error answer carries data");
  a_rdata_idle: assert property (!pready |-> prdata == '0)
    else $error("read data outside access");
  a_on_follows: assert property (ctl_wr |=> adc_on == $past(pwdata[15]))
    else $error("enable output misses write");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_start_sampled: assert property (conv_start |-> $past(sampling))
    else $error("start without sampling");
  // Off for two edges means the sequencer must be quiet
  a_off_quiet: assert property (!adc_on && !$past(adc_on) |->
    !sampling && !conv_start) else $error("activity while off");
  c_start: cover property (conv_start);
  c_err: cover property (pslverr);
  c_off: cover property ($fell(adc_on));
endmodule : asc_ctrl_asserts

bind asc_ctrl asc_ctrl_asserts u_asc_ctrl_asserts (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .conv_start(conv_start), .sampling(sampling),
  .adc_on(adc_on));

// File: tb/asc_core_model.sv
// Behavioural analog core: answers a start pulse with done and result.
// Assumes conv_start is a one-cycle pulse on pclk.
`timescale 1ns/100ps
module asc_core_model (
  input  wire logic       pclk,       // Clock
  input  wire logic       presetn,    // Reset, active low
  input  wire logic       conv_start, // Start pulse
  input  wire logic       slow,       // Long conversion
  input  wire logic [9:0] value,      // Result to return
  output      logic       conv_done,  // Done level
  output      logic [9:0] conv_result // Held only around done
);
  int cnt;
  // Done stands 8 cycles for the synchroniser; outside it the result
  // lines toggle so a late sample is caught
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt         <= 0;
      conv_done   <= 1'b0;
      conv_result <= '0;
    end else begin
      if (conv_start) cnt <= slow ? 28 : 12;
      else if (cnt > 0) cnt <= cnt - 1;
      conv_done   <= cnt > 0 && cnt < 9;
      conv_result <= (cnt > 0 && cnt < 10) ? value : ~conv_result;
    end
  end
endmodule : asc_core_model

// File: tb/adc_sample_convert_control_bench.sv
// Bench for the converter control block: APB, trigger pins, core model.
// Assumes zero-wait APB answers and the design's sync delays.
`timescale 1ns/100ps
module adc_sample_convert_control_bench;
  localparam logic [11:0] CTL = asc_pkg::ADDR_CTRL;
  localparam logic [11:0] STA = asc_pkg::ADDR_STATUS;
  localparam logic [9:0]  RAW = 10'h0a5;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, idle_mode = 1'b0, slow = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [2:0]  trg = '0;
  logic [9:0]  conv_result;
  logic        pready, pslverr, conv_done, conv_start, sampling, adc_on, irq;
  int          err_count = 0, check_count = 0, starts = 0;

  asc_ctrl u_asc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_mode(idle_mode), .ext_pin_zero(trg[0]), .tmr3_match(trg[1]),
    .ctu_event(trg[2]), .conv_done(conv_done), .conv_result(conv_result),
    .conv_start(conv_start), .sampling(sampling), .adc_on(adc_on),
    .irq(irq));
  asc_core_model u_asc_core_model (.pclk(pclk), .presetn(presetn),
    .conv_start(conv_start), .slow(slow), .value(RAW),
    .conv_done(conv_done), .conv_result(conv_result));

  // Clock and a tally of conversion starts
  initial forever #2 pclk = ~pclk;
  always @(posedge pclk) if (conv_start === 1'b1) starts <= starts + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One transfer; an idle edge follows so strobes never double up
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, '0, q, e);
    chk(q, x);
  endtask : rdc

  task automatic wait_start(input int n0, input int lim);
    repeat (lim) if (starts == n0) @(posedge pclk);
    chk(32'(starts != n0), 32'h1);
  endtask : wait_start

  // Expected result word; the raw value is offset binary
  function automatic logic [31:0] fexp(input logic [2:0] f);
    logic [9:0] t;
    t = {~RAW[9], RAW[8:0]};
    case (f)
      3'b000, 3'b100: fexp = {22'h0, RAW};
      3'b001: fexp = {16'h0, {6{t[9]}}, t};
      3'b010: fexp = {16'h0, RAW, 6'h0};
      3'b011: fexp = {16'h0, t, 6'h0};
      3'b101: fexp = {{22{t[9]}}, t};
      3'b110: fexp = {RAW, 22'h0};
      default: fexp = {t, 22'h0};
    endcase
  endfunction : fexp

  // Reset values, unimplemented bits, unmapped address
  task automatic regs();
    logic [31:0] q;
    logic        e;
    rdc(CTL, asc_pkg::CTRL_RESET);
    rdc(asc_pkg::ADDR_SAMPT, {24'h0, asc_pkg::SAMPT_RESET});
    wr(CTL, 32'hffff_7ff5);
    rdc(CTL, 32'hffff_7ff4 & asc_pkg::CTRL_MASK);
    wr(CTL, '0);
    apb(1'b0, 12'h100, '0, q, e);
    chk(q, '0);
    chk({31'h0, e}, 32'h1);
  endtask : regs

  // Software-timed conversion; writing 1 to the done bit keeps it
  task automatic conv(input logic [2:0] f, input logic s);
    int          n0;
    logic [31:0] q;
    logic        e;
    slow <= s;
    n0 = starts;
    wr(CTL, {16'h0, 5'h10, f, 8'h03});
    repeat (20) if (sampling !== 1'b1) @(posedge pclk);
    chk({31'h0, sampling}, 32'h1);
    wr(CTL, {16'h0, 5'h10, f, 8'h01});
    wait_start(n0, 20);
    if (s) rdc(CTL, {16'h0, 5'h10, f, 8'h00});
    q = '0;
    for (int i = 0; i < 40 && q[0] !== 1'b1; i++) apb(1'b0, CTL, '0, q, e);
    chk(q, {16'h0, 5'h10, f, 8'h01});
    rdc(asc_pkg::ADDR_RESULT, fexp(f));
  endtask : conv

  // Done clear, sticky status, mask and interrupt level
  task automatic irq_chk();
    wr(CTL, 32'h0000_8700);
    rdc(CTL, 32'h0000_8700);
    rdc(STA, 32'h3);
    wr(asc_pkg::ADDR_MASK, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(asc_pkg::ADDR_MASK, '0);
    @(posedge pclk);
    chk({31'h0, irq}, '0);
    wr(asc_pkg::ADDR_MASK, 32'h1);
    wr(STA, 32'h3);
    @(posedge pclk);
    chk({31'h0, irq}, '0);
    rdc(STA, '0);
  endtask : irq_chk

  // Auto sampling with a hardware trigger; code 100 must never fire
  task automatic trig(input logic [2:0] c);
    int n0;
    n0 = starts;
    wr(CTL, {16'h0, 5'h10, 3'h0, c, 5'h04});
    repeat (20) if (sampling !== 1'b1) @(posedge pclk);
    chk({31'h0, sampling}, 32'h1);
    if (c != 3'b111) begin
      repeat (16) @(posedge pclk);
      chk(32'(starts - n0), '0);
      if (c < 3'b100) trg[c - 3'd1] <= 1'b1;
      repeat (4) @(posedge pclk);
      trg <= '0;
    end
    if (c != 3'b100) wait_start(n0, 40);
    wr(CTL, '0);
    repeat (30) @(posedge pclk);
  endtask : trig

  // Stop-in-idle holds off auto sampling until idle ends
  task automatic idle_chk();
    int n0;
    n0 = starts;
    idle_mode <= 1'b1;
    wr(CTL, 32'h0000_a0e4);
    repeat (16) @(posedge pclk);
    chk({31'h0, sampling}, '0);
    chk(32'(starts - n0), '0);
    idle_mode <= 1'b0;
    wait_start(n0, 40);
    wr(CTL, '0);
    repeat (30) @(posedge pclk);
  endtask : idle_chk

  task automatic complete_run();
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    regs();
    // Enable first: a sample request in the enabling write is ignored
    wr(CTL, 32'h0000_8000);
    for (int f = 0; f < 8; f++) conv(3'(f), f[0]);
    irq_chk();
    for (int c = 1; c < 8; c++) if (c < 5 || c == 7) trig(3'(c));
    idle_chk();
    complete_run();
  end

  // Watchdog far beyond the under one thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    complete_run();
  end
endmodule : adc_sample_convert_control_bench
